// File: pkg/scs_pkg.sv
// package of offsets, field positions, reset values and timing constants for the clock register bank
`default_nettype none
package scs_pkg;
  // bus geometry
  localparam int unsigned ADDR_W          = 12;         // byte address width on the register bus
  localparam int unsigned DATA_W          = 32;         // register bus data width
  localparam int unsigned REG_W           = 8;          // one byte per register; the interrupt status and mask keep only two bits
  // register indices; byte address is four times the index
  localparam logic [9:0]  IDX_CLK_CTRL0   = 10'h030;    // clock control 0, holds the clear bits
  localparam logic [9:0]  IDX_CLK_STATUS  = 10'h031;    // clock generator status (read only)
  localparam logic [9:0]  IDX_CLK_CTRL2   = 10'h032;    // clock_gen_control_2
  localparam logic [9:0]  IDX_ANALOG_MISC_CONTROL    = 10'h033;    // analog_misc_control
  localparam logic [9:0]  IDX_CLAMP       = 10'h034;    // input_clamp_control
  localparam logic [9:0]  IDX_SERIALIZER_CONFIG     = 10'h040;    // serializer_config
  localparam logic [9:0]  IDX_IRQ_STATUS  = 10'h0f0;    // sticky event bits, write one to clear
  localparam logic [9:0]  IDX_IRQ_MASK    = 10'h0f1;    // interrupt enables, same layout
  // reset values
  localparam logic [7:0]  RST_CLK_CTRL0   = 8'hc0;
  localparam logic [7:0]  RST_CLK_CTRL2   = 8'h80;
  localparam logic [7:0]  RST_ANALOG_MISC_CONTROL    = 8'hc3;
  localparam logic [7:0]  RST_CLAMP       = 8'h2f;
  localparam logic [7:0]  RST_SERIALIZER_CONFIG     = 8'h04;
  localparam logic [1:0]  RST_IRQ_MASK    = 2'h0;
  // fixed low pattern of the status register
  localparam logic [5:0]  STATUS_FIXED    = 6'h07;
  // field positions
  localparam int unsigned POS_EDGE_SEEN   = 7;          // status: reference edge seen
  localparam int unsigned POS_MARGINAL    = 6;          // status: marginal capture
  localparam int unsigned POS_EDGE_CLR    = 5;          // ctrl0: edge_flag_clear
  localparam int unsigned POS_MARG_CLR    = 4;          // ctrl0: marginal_flag_clear
  localparam int unsigned POS_SYNC_PD     = 2;          // analog_misc_control: diff_sync_rx_powerdown
  localparam int unsigned POS_CLAMP_EN    = 5;          // clamp: active clamp enable
  localparam int unsigned FLD_LSB         = 0;          // low nibble fields start here
  localparam int unsigned FLD_NIB_W       = 4;          // delay and pre-emphasis width
  // interrupt bit layout
  localparam int unsigned IRQ_EDGE        = 0;
  localparam int unsigned IRQ_MARG        = 1;
  localparam int unsigned NUM_FLAGS       = 2;
  // timing
  localparam int unsigned CLK_PERIOD_NS   = 50;         // aclk at 20 MHz
  localparam int unsigned REF_STEP_PS     = 20;         // nominal delay per step of the delay field
  localparam int unsigned MARGIN_NS       = 100;        // window after a device clock edge
  localparam int unsigned MARGIN_CYC      = (MARGIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // bus responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage
`default_nettype wire

// File: rtl/scs_flag_clear.sv
// sticky status flag cleared by a one-then-zero sequence on its clear bit
`timescale 1ns/10ps
`default_nettype none
module scs_flag_clear
  import scs_pkg::*;
(
  input  wire logic aclk,        // system clock
  input  wire logic aresetn,     // synchronous reset, active low
  input  wire logic set_event,   // one-cycle qualifying event
  input  wire logic clear_bit,   // software clear control bit
  output logic      flag         // sticky flag
);

  logic clear_prev;              // clear bit one cycle ago
  logic next_flag;               // next flag value
  logic next_clear_prev;         // next delayed clear bit

  // the clear finishes on the one-to-zero step; a new event in that cycle still wins
  always_comb
  begin
    next_clear_prev = clear_bit;
    next_flag       = set_event | (flag & ~(clear_prev & ~clear_bit)); // see [RULE14]
  end

  // registers only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flag       <= 1'b0;
      clear_prev <= 1'b0;
    end
    else
    begin
      flag       <= next_flag;
      clear_prev <= next_clear_prev;
    end
  end

endmodule // scs_flag_clear
`default_nettype wire

// File: rtl/scs_clock_regs.sv
// reference pulse status and clock/serializer control register bank with AXI4-Lite access
// Function
// [RULE1] set edge-seen flag on reference rising edge
// [RULE2] software clears edge flag: write one, zero
// [RULE3] flag reference edges too near device clock
// [RULE4] software clears marginal flag: write one, zero
// [RULE5] software uses realignment flag during timing sweeps
// [RULE6] status low six bits read 000111b
// [RULE7] 4-bit reference delay, 20 ps steps, reset 0
// [RULE8] bit 2 powers down differential sync receiver
// [RULE9] sync receiver also serves time-stamp input
// [RULE10] software keeps receiver powered while in use
// [RULE11] clamp enable bit 5, resets to one
// [RULE12] 4-bit pre-emphasis field, resets to four
// [RULE13] clear bits at control0 bits 5, 4
// [RULE14] flags hold until clear completes; set wins
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module scs_clock_regs
  import scs_pkg::*;
(
  input  wire logic              aclk,                   // system clock, 20 MHz
  input  wire logic              aresetn,                // synchronous reset, active low
  // AXI4-Lite write address
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  // AXI4-Lite write data
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  // AXI4-Lite write response
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  // AXI4-Lite read address
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  // AXI4-Lite read data
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  // pins
  input  wire logic              sysref_in,              // reference pulse pin
  input  wire logic              device_clock_input,     // device clock pin, sampled
  input  wire logic              diff_sync_rx_in,        // differential sync receiver pin
  // controls to the analog side
  output logic [FLD_NIB_W-1:0]   ref_pulse_delay_steps,  // reference delay in steps
  output logic                   diff_sync_rx_powerdown, // high powers the receiver down
  output logic                   input_clamp_enable,     // active input clamp on
  output logic [FLD_NIB_W-1:0]   serializer_preemphasis, // output driver boost
  output logic                   sync_rx_data,           // receiver output for sync use
  output logic                   timestamp_rx_data,      // same receiver for time-stamp use
  output logic                   irq                     // level interrupt
);

  // synchronisers: stage one is read only by stage two
  logic [2:0] pin_s1;            // first stage for sysref, device_clock_input, sync
  logic [2:0] pin_s2;            // second stage, safe to read
  logic [1:0] pin_s3;            // history for edge detection of sysref and device_clock_input
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_s3 <= 2'h0;
    end
    else
    begin
      pin_s1 <= {diff_sync_rx_in, device_clock_input, sysref_in};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2[1:0];
    end
  end

  logic ref_rise;                // reference rising edge seen this cycle
  logic dev_rise;                // device clock rising edge seen this cycle
  assign ref_rise = pin_s2[0] & ~pin_s3[0];
  assign dev_rise = pin_s2[1] & ~pin_s3[1];

  // cycles since the last device clock edge; saturates so it never wraps into the window
  logic [7:0] since_dev;
  logic [7:0] next_since_dev;
  logic       marginal_evt;      // reference edge inside the device clock window
  always_comb
  begin
    next_since_dev = since_dev;
    if (dev_rise)
      next_since_dev = 8'h00;
    else if (since_dev != 8'hff)
      next_since_dev = since_dev + 8'h01;
    // sampled clock limits resolution; edges within the window count as unsafe
    marginal_evt = ref_rise & (dev_rise | (since_dev < 8'(MARGIN_CYC))); // see [RULE3]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      since_dev <= 8'hff;
    else
      since_dev <= next_since_dev;
  end

  // software registers
  logic [REG_W-1:0]     ctrl0;       // clock control 0
  logic [REG_W-1:0]     ctrl2;       // clock_gen_control_2
  logic [REG_W-1:0]     analog_misc_control;    // analog_misc_control
  logic [REG_W-1:0]     clamp;       // input_clamp_control
  logic [REG_W-1:0]     serializer_config;     // serializer_config
  logic [NUM_FLAGS-1:0] irq_status;  // sticky interrupt events
  logic [NUM_FLAGS-1:0] irq_mask;    // interrupt enables

  // status flags, one sticky unit per flag
  logic [NUM_FLAGS-1:0] flag_set;    // set events per flag
  logic [NUM_FLAGS-1:0] flag_clr;    // clear control bits per flag
  logic [NUM_FLAGS-1:0] flags;       // current flags
  assign flag_set[IRQ_EDGE] = ref_rise;                 // see [RULE1]
  assign flag_set[IRQ_MARG] = marginal_evt;             // see [RULE3]
  assign flag_clr[IRQ_EDGE] = ctrl0[POS_EDGE_CLR];      // see [RULE13]
  assign flag_clr[IRQ_MARG] = ctrl0[POS_MARG_CLR];      // see [RULE13]

  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++)
    begin : g_flag
      scs_flag_clear u_flag (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .set_event (flag_set[gi]),
        .clear_bit (flag_clr[gi]),
        .flag      (flags[gi])
      );
    end
  endgenerate

  // status register image; low bits are fixed
  logic [REG_W-1:0] status_img;
  assign status_img = {flags[IRQ_EDGE], flags[IRQ_MARG], STATUS_FIXED}; // see [RULE6]

  // write channel state
  logic              aw_held;          // write address captured
  logic              w_held;           // write data captured
  logic [9:0]        aw_idx;           // captured register index
  logic [REG_W-1:0]  w_byte;           // captured low data byte
  logic              w_lane0;          // low byte lane enabled
  logic              next_aw_held;
  logic              next_w_held;
  logic [9:0]        next_aw_idx;
  logic [REG_W-1:0]  next_w_byte;
  logic              next_w_lane0;
  logic              next_awready;
  logic              next_wready;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              do_write;         // both halves present, commit this cycle

  // register state next values
  logic [REG_W-1:0]     next_ctrl0;
  logic [REG_W-1:0]     next_ctrl2;
  logic [REG_W-1:0]     next_analog_misc_control;
  logic [REG_W-1:0]     next_clamp;
  logic [REG_W-1:0]     next_serializer_config;
  logic [NUM_FLAGS-1:0] next_irq_status;
  logic [NUM_FLAGS-1:0] next_irq_mask;
  logic [NUM_FLAGS-1:0] irq_w1c;       // bits software clears this cycle
  logic                 wr_hit;        // write index is mapped

  // write path: address and data may arrive in either order; response follows both
  always_comb
  begin
    next_aw_held  = aw_held;
    next_w_held   = w_held;
    next_aw_idx   = aw_idx;
    next_w_byte   = w_byte;
    next_w_lane0  = w_lane0;
    next_bvalid   = bvalid;
    next_bresp    = bresp;
    if (awvalid && awready)
    begin
      next_aw_held = 1'b1;
      next_aw_idx  = awaddr[ADDR_W-1:2];
    end
    if (wvalid && wready)
    begin
      next_w_held  = 1'b1;
      next_w_byte  = wdata[REG_W-1:0];
      next_w_lane0 = wstrb[0];
    end
    if (bvalid && bready)
      next_bvalid = 1'b0;
    do_write = aw_held && w_held && !bvalid;
    case (aw_idx)
      IDX_CLK_CTRL0, IDX_CLK_STATUS, IDX_CLK_CTRL2, IDX_ANALOG_MISC_CONTROL,
      IDX_CLAMP, IDX_SERIALIZER_CONFIG, IDX_IRQ_STATUS, IDX_IRQ_MASK: wr_hit = 1'b1;
      default:                                             wr_hit = 1'b0;
    endcase
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    // one write at a time: stop taking halves until the response is gone
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
  end

  // register updates; only the low byte lane carries data, status writes are dropped
  always_comb
  begin
    next_ctrl0    = ctrl0;
    next_ctrl2    = ctrl2;
    next_analog_misc_control = analog_misc_control;
    next_clamp    = clamp;
    next_serializer_config  = serializer_config;
    next_irq_mask = irq_mask;
    irq_w1c       = '0;
    if (do_write && w_lane0)
    begin
      case (aw_idx)
        IDX_CLK_CTRL0:  next_ctrl0    = w_byte;                    // see [RULE13]
        IDX_CLK_CTRL2:  next_ctrl2    = w_byte;                    // see [RULE7]
        IDX_ANALOG_MISC_CONTROL:   next_analog_misc_control = w_byte;                    // see [RULE8]
        IDX_CLAMP:      next_clamp    = w_byte;                    // see [RULE11]
        IDX_SERIALIZER_CONFIG:    next_serializer_config  = w_byte;                    // see [RULE12]
        IDX_IRQ_STATUS: irq_w1c       = w_byte[NUM_FLAGS-1:0];
        IDX_IRQ_MASK:   next_irq_mask = w_byte[NUM_FLAGS-1:0];
        default:        irq_w1c       = '0;                        // read-only or unmapped
      endcase
    end
    // a new event in the clearing cycle survives
    next_irq_status = (irq_status & ~irq_w1c) | flag_set;
  end

  // read channel next values
  logic              next_arready;
  logic              next_rvalid;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0]        next_rresp;
  logic [9:0]        ar_idx;           // index of the read address
  logic [REG_W-1:0]  rd_byte;          // selected register byte
  logic              rd_hit;           // read index is mapped

  // read path: answer one cycle after the address is taken
  always_comb
  begin
    ar_idx       = araddr[ADDR_W-1:2];
    next_arready = arready;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    rd_hit       = 1'b1;
    case (ar_idx)
      IDX_CLK_CTRL0:  rd_byte = ctrl0;
      IDX_CLK_STATUS: rd_byte = status_img;                          // see [RULE6]
      IDX_CLK_CTRL2:  rd_byte = ctrl2;
      IDX_ANALOG_MISC_CONTROL:   rd_byte = analog_misc_control;
      IDX_CLAMP:      rd_byte = clamp;
      IDX_SERIALIZER_CONFIG:    rd_byte = serializer_config;
      IDX_IRQ_STATUS: rd_byte = {{(REG_W-NUM_FLAGS){1'b0}}, irq_status};
      IDX_IRQ_MASK:   rd_byte = {{(REG_W-NUM_FLAGS){1'b0}}, irq_mask};
      default:
      begin
        rd_byte = 8'h00;
        rd_hit  = 1'b0;
      end
    endcase
    if (arvalid && arready)
    begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rdata   = {{(DATA_W-REG_W){1'b0}}, rd_byte};
      next_rresp   = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
  end

  // output images; all registered so the ports come from flip-flops
  logic next_sync_data;
  logic next_ts_data;
  logic next_irq;
  always_comb
  begin
    // a powered-down receiver gives a quiet low on both users
    next_sync_data = pin_s2[2] & ~analog_misc_control[POS_SYNC_PD];             // see [RULE8]
    next_ts_data   = pin_s2[2] & ~analog_misc_control[POS_SYNC_PD];             // see [RULE9]
    next_irq       = |(next_irq_status & next_irq_mask);
  end

  // bus, software register and output state; synchronisers, since_dev and flags live elsewhere
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held    <= 1'b0;
      w_held     <= 1'b0;
      aw_idx     <= 10'h000;
      w_byte     <= 8'h00;
      w_lane0    <= 1'b0;
      awready    <= 1'b0;
      wready     <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= RESP_OKAY;
      arready    <= 1'b0;
      rvalid     <= 1'b0;
      rdata      <= 32'h0000_0000;
      rresp      <= RESP_OKAY;
      ctrl0      <= RST_CLK_CTRL0;
      ctrl2      <= RST_CLK_CTRL2;
      analog_misc_control   <= RST_ANALOG_MISC_CONTROL;
      clamp      <= RST_CLAMP;
      serializer_config    <= RST_SERIALIZER_CONFIG;
      irq_status <= '0;
      irq_mask   <= RST_IRQ_MASK;
      irq        <= 1'b0;
      sync_rx_data      <= 1'b0;
      timestamp_rx_data <= 1'b0;
    end
    else
    begin
      aw_held    <= next_aw_held;
      w_held     <= next_w_held;
      aw_idx     <= next_aw_idx;
      w_byte     <= next_w_byte;
      w_lane0    <= next_w_lane0;
      awready    <= next_awready;
      wready     <= next_wready;
      bvalid     <= next_bvalid;
      bresp      <= next_bresp;
      // ready comes up the cycle after reset release
      arready    <= next_arready | (!arready && !rvalid);
      rvalid     <= next_rvalid;
      rdata      <= next_rdata;
      rresp      <= next_rresp;
      ctrl0      <= next_ctrl0;
      ctrl2      <= next_ctrl2;
      analog_misc_control   <= next_analog_misc_control;
      clamp      <= next_clamp;
      serializer_config    <= next_serializer_config;
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
      irq        <= next_irq;
      sync_rx_data      <= next_sync_data;
      timestamp_rx_data <= next_ts_data;
    end
  end

  // field outputs straight from the register flip-flops
  assign ref_pulse_delay_steps  = ctrl2[FLD_LSB +: FLD_NIB_W];        // see [RULE7]
  assign diff_sync_rx_powerdown = analog_misc_control[POS_SYNC_PD];              // see [RULE8]
  assign input_clamp_enable     = clamp[POS_CLAMP_EN];                // see [RULE11]
  assign serializer_preemphasis = serializer_config[FLD_LSB +: FLD_NIB_W];      // see [RULE12]

endmodule // scs_clock_regs
`default_nettype wire

// File: dv/scs_clock_regs_asserts.sv
// port checker for the clock register bank
`timescale 1ns/10ps
`default_nettype none
module scs_clock_regs_asserts
  import scs_pkg::*;
(
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 arvalid,
  input wire logic                 arready,
  input wire logic [ADDR_W-1:0]    araddr,
  input wire logic                 rvalid,
  input wire logic                 rready,
  input wire logic [DATA_W-1:0]    rdata,
  input wire logic                 bvalid,
  input wire logic                 bready,
  input wire logic [1:0]           bresp,
  input wire logic [FLD_NIB_W-1:0] ref_pulse_delay_steps,
  input wire logic                 diff_sync_rx_powerdown,
  input wire logic                 input_clamp_enable,
  input wire logic [FLD_NIB_W-1:0] serializer_preemphasis,
  input wire logic                 sync_rx_data,
  input wire logic                 timestamp_rx_data
);
  logic rd_status; // last accepted read aimed at the status register
  // remember the target so the answer can be judged when rvalid shows
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rd_status <= 1'b0;
    else if (arvalid && arready)
      rd_status <= (araddr == {IDX_CLK_STATUS, 2'b00});
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // reset must be seen while it is asserted, so no disable here
  a_reset_ctrl: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> ref_pulse_delay_steps == 4'h0 && !diff_sync_rx_powerdown
      && input_clamp_enable && serializer_preemphasis == RST_SERIALIZER_CONFIG[3:0])
    else $error("control outputs not at reset values");
  a_ctrl_by_write: assert property ($past(aresetn) && $changed({ref_pulse_delay_steps,
    diff_sync_rx_powerdown, input_clamp_enable, serializer_preemphasis}) |-> $rose(bvalid))
    else $error("control output moved without a write answer");
  a_pd_gates_rx: assert property (diff_sync_rx_powerdown && $past(diff_sync_rx_powerdown)
    |-> !sync_rx_data && !timestamp_rx_data)
    else $error("receiver output active while powered down");
  a_ts_same_rx: assert property (sync_rx_data == timestamp_rx_data)
    else $error("time-stamp and sync receiver outputs differ");
  a_status_fixed: assert property (rvalid && rd_status |->
    rdata[5:0] == STATUS_FIXED && rdata[31:8] == 24'h0)
    else $error("status low bits not fixed pattern");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer missing one cycle after address");
  a_read_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before taken");
  a_write_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");
endmodule // scs_clock_regs_asserts
bind scs_clock_regs scs_clock_regs_asserts i_chk (.*);
`default_nettype wire

// File: dv/scs_clock_source.sv
// board clock source: free device clock and reference pulses on demand
`timescale 1ns/10ps
`default_nettype none
module scs_clock_source
(
  output var logic device_clock_input, // free running, 8 system cycles a period
  output var logic sysref_in           // reference pulse, driven low between pulses
);
  // device clock runs free; edges land on system clock falling edges, between rising edges
  initial
  begin
    device_clock_input = 1'b0;
    forever #200 device_clock_input = ~device_clock_input;
  end
  initial sysref_in = 1'b0;
  // near launches on a device clock rise (marginal); else half a period later
  task automatic send_pulse(input logic near);
    @(posedge device_clock_input);
    if (!near)
      #200;
    sysref_in = 1'b1;
    repeat (2) @(posedge device_clock_input);
    sysref_in = 1'b0;
  endtask
endmodule // scs_clock_source
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for the clock register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import scs_pkg::*;
  logic                 aclk, aresetn;           // clock and reset
  logic                 awvalid, awready, wvalid, wready, bvalid, bready;
  logic                 arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0]    awaddr, araddr;           // byte addresses
  logic [2:0]           awprot, arprot;           // unused by the bank, held 0
  logic [DATA_W-1:0]    wdata, rdata;
  logic [3:0]           wstrb;
  logic [1:0]           bresp, rresp;
  logic                 sysref_in, device_clock_input, diff_sync_rx_in;
  logic [FLD_NIB_W-1:0] ref_pulse_delay_steps, serializer_preemphasis;
  logic                 diff_sync_rx_powerdown, input_clamp_enable;
  logic                 sync_rx_data, timestamp_rx_data, irq;
  int                   error_cnt, total_checks, cyc;
  logic [5:0]           fx;                       // fixed status pattern
  assign fx = STATUS_FIXED;
  scs_clock_regs i_dut (.*);
  scs_clock_source i_src (.device_clock_input(device_clock_input), .sysref_in(sysref_in));
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask
  // write one byte; readies are registered so the negedge view holds at the edge
  task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic ta, tw;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= {i, 2'b00};
    wvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= s;
    bready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge aclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
    end while (awvalid || wvalid);
    do @(negedge aclk); while (!bvalid);
    chk("bresp", 32'(er), 32'(bresp));
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] i, input logic [7:0] e, input logic [1:0] er);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= {i, 2'b00};
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    chk("rdata", {24'h0, e}, rdata);
    chk("rresp", 32'(er), 32'(rresp));
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic t_reset;
    rd(IDX_CLK_CTRL0, RST_CLK_CTRL0, RESP_OKAY);
    rd(IDX_CLK_STATUS, {2'b00, fx}, RESP_OKAY);
    rd(IDX_CLK_CTRL2, RST_CLK_CTRL2, RESP_OKAY);
    rd(IDX_ANALOG_MISC_CONTROL, RST_ANALOG_MISC_CONTROL, RESP_OKAY);
    rd(IDX_CLAMP, RST_CLAMP, RESP_OKAY);
    rd(IDX_SERIALIZER_CONFIG, RST_SERIALIZER_CONFIG, RESP_OKAY);
    rd(IDX_IRQ_MASK, {6'h0, RST_IRQ_MASK}, RESP_OKAY);
    rd(10'h035, 8'h00, RESP_SLVERR);
    wr(10'h035, 8'hff, 4'h1, RESP_SLVERR);
    chk("delay", 32'h0, 32'(ref_pulse_delay_steps));
    chk("clamp", 32'h1, 32'(input_clamp_enable));
    chk("preemphasis", 32'h4, 32'(serializer_preemphasis));
    $display("test reset done");
  endtask
  task automatic t_fields;
    wr(IDX_CLK_CTRL2, 8'h8f, 4'h1, RESP_OKAY);
    chk("delay", 32'hf, 32'(ref_pulse_delay_steps));
    rd(IDX_CLK_CTRL2, 8'h8f, RESP_OKAY);
    diff_sync_rx_in <= 1'b1;
    wr(IDX_ANALOG_MISC_CONTROL, RST_ANALOG_MISC_CONTROL | 8'h04, 4'h1, RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk("powerdown", 32'h1, 32'(diff_sync_rx_powerdown));
    chk("sync_rx", 32'h0, 32'(sync_rx_data));
    wr(IDX_ANALOG_MISC_CONTROL, RST_ANALOG_MISC_CONTROL, 4'h1, RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk("sync_rx", 32'h1, 32'(sync_rx_data));
    chk("ts_rx", 32'h1, 32'(timestamp_rx_data));
    wr(IDX_CLAMP, 8'h0f, 4'h1, RESP_OKAY);
    chk("clamp", 32'h0, 32'(input_clamp_enable));
    wr(IDX_SERIALIZER_CONFIG, 8'h0f, 4'h1, RESP_OKAY);
    wr(IDX_SERIALIZER_CONFIG, 8'h00, 4'h0, RESP_OKAY);
    chk("preemphasis", 32'hf, 32'(serializer_preemphasis));
    wr(IDX_CLK_STATUS, 8'hff, 4'h1, RESP_OKAY);
    rd(IDX_CLK_STATUS, {2'b00, fx}, RESP_OKAY);
    $display("test fields done");
  endtask
  task automatic t_flags;
    wr(IDX_IRQ_MASK, 8'h03, 4'h1, RESP_OKAY);
    i_src.send_pulse(1'b0);
    rd(IDX_CLK_STATUS, {2'b10, fx}, RESP_OKAY);
    chk("irq", 32'h1, 32'(irq));
    wr(IDX_CLK_CTRL0, RST_CLK_CTRL0 | 8'h20, 4'h1, RESP_OKAY);
    rd(IDX_CLK_STATUS, {2'b10, fx}, RESP_OKAY);
    wr(IDX_CLK_CTRL0, RST_CLK_CTRL0, 4'h1, RESP_OKAY);
    rd(IDX_CLK_STATUS, {2'b00, fx}, RESP_OKAY);
    wr(IDX_IRQ_STATUS, 8'h01, 4'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq", 32'h0, 32'(irq));
    i_src.send_pulse(1'b1);
    rd(IDX_CLK_STATUS, {2'b11, fx}, RESP_OKAY);
    wr(IDX_CLK_CTRL0, RST_CLK_CTRL0 | 8'h10, 4'h1, RESP_OKAY);
    wr(IDX_CLK_CTRL0, RST_CLK_CTRL0, 4'h1, RESP_OKAY);
    rd(IDX_CLK_STATUS, {2'b10, fx}, RESP_OKAY);
    rd(IDX_IRQ_STATUS, 8'h03, RESP_OKAY);
    wr(IDX_IRQ_STATUS, 8'h03, 4'h1, RESP_OKAY);
    wr(IDX_IRQ_MASK, 8'h00, 4'h1, RESP_OKAY);
    i_src.send_pulse(1'b0);
    chk("irq", 32'h0, 32'(irq));
    $display("test flags done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // a hang ends the run here; the tests need well under a thousand cycles
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      $display("unexpected timeout expected done seen hang");
      stop_test();
    end
  end
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, diff_sync_rx_in} = 7'h0;
    {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_fields();
    t_flags();
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
